//--- icm_pkg.sv
package icm_pkg;
  // ****************
  // sizes and timing
  // ****************
  localparam int NUM_IN = 8;
  localparam int CLK_HZ = 100_000_000;
  localparam int INTERVAL_MS = 128;
  localparam int INTERVAL_CYC = (CLK_HZ / 1000) * INTERVAL_MS;
  localparam int MISS_STD = 3;
  localparam int MISS_HIGH = 5;
  localparam int TOL_MUL = 41;
  localparam int TOL_SHIFT = 12;

  // ****************
  // register offsets
  // ****************
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_DIVR = 8'h04;
  localparam logic [7:0] ADR_VALID_A = 8'h08;
  localparam logic [7:0] ADR_LAT_A = 8'h0C;
  localparam logic [7:0] ADR_LAT_B = 8'h10;
  localparam logic [7:0] ADR_LAT_C = 8'h14;
  localparam logic [7:0] ADR_IEN_A = 8'h18;
  localparam logic [7:0] ADR_IEN_B = 8'h1C;
  localparam logic [7:0] ADR_ALARM = 8'h20;
  localparam logic [7:0] ADR_STATE = 8'h24;
  localparam logic [3:0] ADR_BKT_HI = 4'h3;
  localparam logic [1:0] ADR_CFG_HI = 2'h1;

  // ****************
  // field positions
  // ****************
  localparam int CTRL_INPUT_SELECT_A_MONITOR_ENABLE_BIT = 0;
  localparam int CTRL_PIN_BIT = 1;
  localparam int CTRL_NO_ACTIVITY_LOSS_OF_LOCK_BIT = 2;
  localparam int CTRL_POL_BIT = 3;
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_BKT_LSB = 2;
  localparam int CFG_HIGH_BIT = 4;
  localparam int CFG_HALVE_BIT = 5;
  localparam int CFG_LOW_BIT = 6;
  localparam int CFG_PER_LSB = 16;
  localparam int BKT_CAP_LSB = 0;
  localparam int BKT_DECL_LSB = 8;
  localparam int BKT_CLR_LSB = 16;
  localparam int BKT_DEC_LSB = 24;

  // ****************
  // reset values
  // ****************
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam logic [15:0] DIVR_RST = 16'h0000;
  localparam logic [31:0] CFG_RST = 32'h30D4_0000;
  localparam logic [31:0] PDIV_RST = 32'h0000_0000;
  localparam logic [31:0] BKT_RST = 32'h0001_080A;

  typedef enum logic [1:0] {
    MODE_DIRECT = 2'b00,
    MODE_EIGHT_KHZ_LOCK_SELECT = 2'b01,
    MODE_DIVIDE_RATIO = 2'b10,
    MODE_ALT = 2'b11
  } icm_mode_e;

  typedef enum logic [1:0] {
    MAIN_TRACK = 2'b00,
    MAIN_HOLD = 2'b01,
    MAIN_LOL = 2'b10
  } icm_main_e;
endpackage

//--- icm_bkt_if.sv
`timescale 1ns/100ps
interface icm_bkt_if;
  logic tick;
  logic fill;
  logic [7:0] capacity;
  logic [7:0] declare;
  logic [7:0] clear_lvl;
  logic [1:0] decay;
  logic alarm;
  modport bucket(input tick, fill, capacity, declare, clear_lvl, decay,
                 output alarm);
  modport ctrl(output tick, fill, capacity, declare, clear_lvl, decay,
               input alarm);
endinterface

//--- icm_bucket.sv
`timescale 1ns/100ps
module icm_bucket (
  input wire logic clk_i,
  input wire logic rst_i,
  icm_bkt_if.bucket bk
);
  logic [7:0] lvl_r;
  logic pend_r;
  logic [2:0] per_r;
  logic alarm_r;
  logic hit;
  logic [2:0] last;

  assign hit = pend_r | bk.fill;
  assign last = 3'((4'h1 << bk.decay) - 4'h1);
  assign bk.alarm = alarm_r;

  // at most one fill per interval, remembered until its end
  always_ff @(posedge clk_i) begin
    if (rst_i || bk.tick) begin
      pend_r <= 1'b0;
    end else if (bk.fill) begin
      pend_r <= 1'b1; // [R14]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lvl_r <= 8'h00;
      per_r <= 3'h0;
    end else if (bk.tick) begin
      if (hit) begin
        per_r <= 3'h0; // [R15]
        if (lvl_r < bk.capacity) begin
          lvl_r <= lvl_r + 8'h01; // [R14]
        end else begin
          lvl_r <= bk.capacity; // [R17]
        end
      end else if (per_r == last) begin
        per_r <= 3'h0;
        if (lvl_r != 8'h00) begin
          lvl_r <= lvl_r - 8'h01; // [R15]
        end
      end else begin
        per_r <= per_r + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alarm_r <= 1'b0;
    end else if (lvl_r >= bk.declare) begin
      alarm_r <= 1'b1; // [R16]
    end else if (lvl_r <= bk.clear_lvl) begin
      alarm_r <= 1'b0; // [R16]
    end
  end
endmodule

//--- icm_input_mon.sv
`timescale 1ns/100ps
module icm_input_mon (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ref_i,
  input wire logic fall_i,
  input wire logic [31:0] cfg_i,
  input wire logic [15:0] pdiv_i,
  input wire logic [15:0] divide_ratio_i,
  output logic edge_o,
  output logic miss_o,
  output logic input_select_a_bad_o,
  output logic lock_tick_o
);
  logic [1:0] sync_r;
  logic ref_d_r;
  logic edge_w;
  logic [19:0] cnt_r;
  logic [15:0] per;
  logic [19:0] limit;
  logic [23:0] tol;
  logic [19:0] hi;
  logic [19:0] lo;
  logic [15:0] dcnt_r;
  logic [15:0] term;
  icm_pkg::icm_mode_e mode;

  assign per = cfg_i[icm_pkg::CFG_PER_LSB +: 16];
  assign mode = icm_pkg::icm_mode_e'(cfg_i[icm_pkg::CFG_MODE_LSB +: 2]);
  assign limit = {4'h0, per} * (cfg_i[icm_pkg::CFG_HIGH_BIT] ?
    20'(icm_pkg::MISS_HIGH) : 20'(icm_pkg::MISS_STD)); // [R14] [R19]
  assign tol = ({8'h00, per} * 24'(icm_pkg::TOL_MUL)) >> icm_pkg::TOL_SHIFT;
  assign hi = {4'h0, per} + tol[19:0];
  assign lo = {4'h0, per} - tol[19:0];

  // ref is asynchronous to clk_i
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_r <= 2'b00;
      ref_d_r <= 1'b0;
    end else begin
      sync_r <= {sync_r[0], ref_i}; // [R24]
      ref_d_r <= sync_r[1];
    end
  end

  assign edge_w = fall_i ? (ref_d_r & ~sync_r[1]) : (~ref_d_r & sync_r[1]);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= 20'h0_0000;
      edge_o <= 1'b0;
      miss_o <= 1'b0;
      input_select_a_bad_o <= 1'b0;
    end else begin
      edge_o <= edge_w;
      miss_o <= ~edge_w && (cnt_r == limit); // [R14]
      if (edge_w) begin
        cnt_r <= 20'h0_0001;
        input_select_a_bad_o <= (cnt_r < lo) || (cnt_r > hi); // [R12] [R19]
      end else begin
        // a dead input keeps missing, so re-arm one period back
        if (cnt_r == limit) begin
          cnt_r <= limit - {4'h0, per} + 20'h0_0001; // [R14]
        end else if (cnt_r != 20'hF_FFFF) begin
          cnt_r <= cnt_r + 20'h0_0001;
        end
        if (cnt_r > hi) begin
          input_select_a_bad_o <= 1'b1;
        end
      end
    end
  end

  // terminal count of the lock divider per locking mode
  always_comb begin
    unique case (mode)
      icm_pkg::MODE_DIRECT: term = {15'h0000, cfg_i[icm_pkg::CFG_HALVE_BIT]};
      icm_pkg::MODE_EIGHT_KHZ_LOCK_SELECT: term = cfg_i[icm_pkg::CFG_LOW_BIT] ?
                                   16'h0000 : pdiv_i; // [R5] [R6]
      icm_pkg::MODE_DIVIDE_RATIO: term = divide_ratio_i; // [R7]
      icm_pkg::MODE_ALT: term = pdiv_i; // [R4]
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dcnt_r <= 16'h0000;
      lock_tick_o <= 1'b0;
    end else begin
      lock_tick_o <= edge_w && (dcnt_r >= term); // [R1] [R3]
      if (edge_w) begin
        dcnt_r <= (dcnt_r >= term) ? 16'h0000 : dcnt_r + 16'h0001;
      end
    end
  end
endmodule

//--- icm_top.sv
`timescale 1ns/100ps
// Operation
// R1: mode bits: 00 direct, 01 divide-to-8k, 10 divide-by-N, 11 alternate.
// R2: software uses direct lock only at listed standard rates.
// R3: direct lock at 155.52MHz halves the input to 77.76MHz.
// R4: alternate direct pre-divides Ethernet rates to 31.25MHz or 5MHz.
// R5: divide-to-8k mode divides reference to 8kHz for locking.
// R6: 2k/4k inputs ignore the 8k select; never 8k mode at 5MHz.
// R7: divide-by-N uses shared 16-bit value plus one.
// R8: software keeps divide-by-N inputs at or below 155.52MHz.
// R9: real-time valid per input; changes latch a flag and may interrupt.
// R10: invalid inputs are excluded from selection for both loops.
// R11: aux no-input flag set when aux loop has no valid input.
// R12: inputs off by over 1% are invalid unless monitor disabled.
// R13: each input picks one of four bucket configurations.
// R14: bucket fills at most once per 128ms interval with missed cycles.
// R15: bucket leaks once per 1/2/4/8 clean intervals, not on fill.
// R16: declare level sets alarm and invalidates; clear level clears it.
// R17: bucket saturates at its capacity.
// R18: software keeps capacity >= declare > clear.
// R19: each loop has a fast monitor for frequency and missing cycles.
// R20: main no-activity enters mini-holdover, sets fail flag, optional pin.
// R21: with loss-of-lock control off, resume nearest-edge tracking.
// R22: with control on, enter loss-of-lock, flag it, relock phase/frequency.
// R23: aux never sets fail flag; may drop lock and flag change.
// R24: references are synchronised to the system clock first.
module icm_top #(
  parameter int INTERVAL_CYCLES = icm_pkg::INTERVAL_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [7:0] ref_clk_i,
  input wire logic [2:0] main_sel_i,
  input wire logic [2:0] aux_sel_i,
  input wire logic [7:0] aux_usable_i,
  output logic [7:0] ref_valid_o,
  output logic [7:0] lock_tick_o,
  output logic main_mini_holdover_o,
  output logic main_lol_o,
  output logic main_input_select_a_err_o,
  output logic aux_input_select_a_err_o,
  output logic aux_locked_o,
  output logic ref_fail_pin_o,
  output logic irq_o
);
  // ****************
  // registers
  // ****************
  logic [31:0] ctrl_r;
  logic [15:0] divide_ratio_r;
  logic [31:0] cfg_r [icm_pkg::NUM_IN];
  logic [15:0] pdiv_r [icm_pkg::NUM_IN];
  logic [31:0] bkt_r [4];
  logic [7:0] lat_a_r;
  logic [1:0] lat_b_r;
  logic [1:0] lat_c_r;
  logic [7:0] ien_a_r;
  logic [3:0] ien_b_r;
  logic [31:0] rd_nxt;
  logic ack_r;
  logic wr;
  logic [31:0] wmask;

  // ****************
  // monitors
  // ****************
  logic [7:0] edge_w;
  logic [7:0] miss_w;
  logic [7:0] fbad_w;
  logic [7:0] fbad_d_r;
  logic [7:0] alarm_w;
  logic [7:0] valid_w;
  logic [7:0] valid_r;
  logic [23:0] ivl_r;
  logic ivl_tick;
  logic input_select_a_monitor_enable;
  logic no_activity_loss_of_lock;
  icm_pkg::icm_main_e main_r;
  icm_pkg::icm_main_e main_nxt;
  logic aux_locked_r;
  logic aux_no_input;
  logic main_noact;
  logic aux_noact;
  logic selected_ref_fail_set;
  logic lol_set;
  logic aux_chg;

  function automatic logic [31:0] byte_mask(input logic [3:0] sel);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int b = 0; b < 4; b++) begin
      m[8*b +: 8] = {8{sel[b]}};
    end
    return m;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [31:0] m);
    return (old & ~m) | (nw & m);
  endfunction

  assign input_select_a_monitor_enable = ctrl_r[icm_pkg::CTRL_INPUT_SELECT_A_MONITOR_ENABLE_BIT];
  assign no_activity_loss_of_lock = ctrl_r[icm_pkg::CTRL_NO_ACTIVITY_LOSS_OF_LOCK_BIT];
  assign wmask = byte_mask(wb_sel_i);
  // write lands on the edge where the master sees ack
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;
  assign wb_ack_o = ack_r;

  // ****************
  // interval divider
  // ****************
  always_ff @(posedge clk_i) begin
    if (rst_i || ivl_tick) begin
      ivl_r <= 24'h00_0000;
    end else begin
      ivl_r <= ivl_r + 24'h00_0001;
    end
  end

  assign ivl_tick = (ivl_r == 24'(INTERVAL_CYCLES - 1)); // [R14]

  // ****************
  // per-input monitors
  // ****************
  for (genvar i = 0; i < icm_pkg::NUM_IN; i++) begin : g_in
    icm_bkt_if bk();
    logic [1:0] bsel;

    icm_input_mon u_mon (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ref_i(ref_clk_i[i]),
      .fall_i(ctrl_r[icm_pkg::CTRL_POL_BIT]),
      .cfg_i(cfg_r[i]),
      .pdiv_i(pdiv_r[i]),
      .divide_ratio_i(divide_ratio_r),
      .edge_o(edge_w[i]),
      .miss_o(miss_w[i]),
      .input_select_a_bad_o(fbad_w[i]),
      .lock_tick_o(lock_tick_o[i])
    );

    assign bsel = cfg_r[i][icm_pkg::CFG_BKT_LSB +: 2]; // [R13]
    assign bk.tick = ivl_tick;
    // frequency excursions count as bucket events too
    assign bk.fill = miss_w[i] | (input_select_a_monitor_enable & fbad_w[i] & ~fbad_d_r[i]);
    assign bk.capacity = bkt_r[bsel][icm_pkg::BKT_CAP_LSB +: 8];
    assign bk.declare = bkt_r[bsel][icm_pkg::BKT_DECL_LSB +: 8];
    assign bk.clear_lvl = bkt_r[bsel][icm_pkg::BKT_CLR_LSB +: 8];
    assign bk.decay = bkt_r[bsel][icm_pkg::BKT_DEC_LSB +: 2];
    assign alarm_w[i] = bk.alarm;

    icm_bucket u_bkt (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .bk(bk)
    );

    assign valid_w[i] = ~alarm_w[i] & ~(input_select_a_monitor_enable & fbad_w[i]); // [R12] [R16]
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fbad_d_r <= 8'h00;
      valid_r <= 8'h00;
    end else begin
      fbad_d_r <= fbad_w;
      valid_r <= valid_w;
    end
  end

  assign ref_valid_o = valid_r; // [R10]
  assign aux_no_input = ~|(valid_r & aux_usable_i); // [R11]

  // ****************
  // fast monitors
  // ****************
  assign main_noact = miss_w[main_sel_i]; // [R19]
  assign aux_noact = miss_w[aux_sel_i]; // [R19]

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      main_input_select_a_err_o <= 1'b0;
      aux_input_select_a_err_o <= 1'b0;
    end else begin
      main_input_select_a_err_o <= fbad_w[main_sel_i]; // [R19]
      aux_input_select_a_err_o <= fbad_w[aux_sel_i]; // [R19]
    end
  end

  always_comb begin
    main_nxt = main_r;
    selected_ref_fail_set = 1'b0;
    lol_set = 1'b0;
    unique case (main_r)
      icm_pkg::MAIN_TRACK: begin
        if (main_noact) begin
          selected_ref_fail_set = 1'b1; // [R20]
          if (no_activity_loss_of_lock) begin
            main_nxt = icm_pkg::MAIN_LOL; // [R22]
            lol_set = 1'b1; // [R22]
          end else begin
            main_nxt = icm_pkg::MAIN_HOLD; // [R20] [R21]
          end
        end
      end
      icm_pkg::MAIN_HOLD: begin
        if (edge_w[main_sel_i]) begin
          main_nxt = icm_pkg::MAIN_TRACK; // [R21]
        end
      end
      icm_pkg::MAIN_LOL: begin
        if (edge_w[main_sel_i]) begin
          main_nxt = icm_pkg::MAIN_TRACK; // [R22]
        end
      end
      default: main_nxt = icm_pkg::MAIN_TRACK;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      main_r <= icm_pkg::MAIN_TRACK;
    end else begin
      main_r <= main_nxt;
    end
  end

  // holdover covers loss of lock too; the loop must not track a dead ref
  assign main_mini_holdover_o = (main_r != icm_pkg::MAIN_TRACK); // [R20]
  // high selects phase/frequency relock, low nearest-edge tracking
  assign main_lol_o = (main_r == icm_pkg::MAIN_LOL); // [R21] [R22]

  // aux loop: never touches the fail flag
  assign aux_chg = (no_activity_loss_of_lock & aux_noact & aux_locked_r) |
                   (edge_w[aux_sel_i] & ~aux_locked_r);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aux_locked_r <= 1'b0;
    end else if (no_activity_loss_of_lock && aux_noact) begin
      aux_locked_r <= 1'b0; // [R23]
    end else if (edge_w[aux_sel_i]) begin
      aux_locked_r <= 1'b1;
    end
  end

  assign aux_locked_o = aux_locked_r;

  // ****************
  // latched status
  // ****************
  // hardware set wins over a same-cycle write-one clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lat_a_r <= 8'h00;
      lat_b_r <= 2'b00;
      lat_c_r <= 2'b00;
    end else begin
      lat_a_r <= (lat_a_r & ~((wr && wb_adr_i == icm_pkg::ADR_LAT_A) ?
                 (wb_dat_i[7:0] & wmask[7:0]) : 8'h00))
                 | (valid_w ^ valid_r); // [R9]
      lat_b_r <= (lat_b_r & ~((wr && wb_adr_i == icm_pkg::ADR_LAT_B) ?
                 (wb_dat_i[1:0] & wmask[1:0]) : 2'b00))
                 | {lol_set, selected_ref_fail_set}; // [R20] [R22]
      lat_c_r <= (lat_c_r & ~((wr && wb_adr_i == icm_pkg::ADR_LAT_C) ?
                 (wb_dat_i[1:0] & wmask[1:0]) : 2'b00))
                 | {aux_chg, aux_no_input}; // [R11] [R23]
    end
  end

  assign ref_fail_pin_o = ctrl_r[icm_pkg::CTRL_PIN_BIT] & lat_b_r[0]; // [R20]
  assign irq_o = |(lat_a_r & ien_a_r) |
                 |({lat_c_r, lat_b_r} & ien_b_r); // [R9] [R22] [R23]

  // ****************
  // bus slave
  // ****************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      ack_r <= wb_cyc_i & wb_stb_i & ~ack_r;
      wb_dat_o <= rd_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= icm_pkg::CTRL_RST;
      divide_ratio_r <= icm_pkg::DIVR_RST;
      ien_a_r <= 8'h00;
      ien_b_r <= 4'h0;
    end else if (wr) begin
      if (wb_adr_i == icm_pkg::ADR_CTRL) begin
        ctrl_r <= merge(ctrl_r, wb_dat_i, wmask) & 32'h0000_000F;
      end
      if (wb_adr_i == icm_pkg::ADR_DIVR) begin
        divide_ratio_r <= 16'(merge({16'h0000, divide_ratio_r}, wb_dat_i,
                                    wmask)); // [R7]
      end
      if (wb_adr_i == icm_pkg::ADR_IEN_A) begin
        ien_a_r <= 8'(merge({24'h00_0000, ien_a_r}, wb_dat_i, wmask));
      end
      if (wb_adr_i == icm_pkg::ADR_IEN_B) begin
        ien_b_r <= 4'(merge({28'h000_0000, ien_b_r}, wb_dat_i, wmask));
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < icm_pkg::NUM_IN; i++) begin
        cfg_r[i] <= icm_pkg::CFG_RST;
        pdiv_r[i] <= icm_pkg::PDIV_RST[15:0];
      end
      for (int k = 0; k < 4; k++) begin
        bkt_r[k] <= icm_pkg::BKT_RST;
      end
    end else if (wr) begin
      if (wb_adr_i[7:6] == icm_pkg::ADR_CFG_HI) begin
        if (!wb_adr_i[2]) begin
          cfg_r[wb_adr_i[5:3]] <= merge(cfg_r[wb_adr_i[5:3]], wb_dat_i,
                                        wmask) & 32'hFFFF_007F; // [R1]
        end else begin
          pdiv_r[wb_adr_i[5:3]] <= 16'(merge({16'h0000,
            pdiv_r[wb_adr_i[5:3]]}, wb_dat_i, wmask));
        end
      end
      if (wb_adr_i[7:4] == icm_pkg::ADR_BKT_HI) begin
        bkt_r[wb_adr_i[3:2]] <= merge(bkt_r[wb_adr_i[3:2]], wb_dat_i,
                                      wmask) & 32'h03FF_FFFF; // [R13]
      end
    end
  end

  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (wb_adr_i[7:6] == icm_pkg::ADR_CFG_HI) begin
      rd_nxt = wb_adr_i[2] ? {16'h0000, pdiv_r[wb_adr_i[5:3]]}
                           : cfg_r[wb_adr_i[5:3]];
    end else if (wb_adr_i[7:4] == icm_pkg::ADR_BKT_HI) begin
      rd_nxt = bkt_r[wb_adr_i[3:2]];
    end else begin
      unique case (wb_adr_i)
        icm_pkg::ADR_CTRL: rd_nxt = ctrl_r;
        icm_pkg::ADR_DIVR: rd_nxt = {16'h0000, divide_ratio_r};
        icm_pkg::ADR_VALID_A: rd_nxt = {24'h00_0000, valid_r};
        icm_pkg::ADR_LAT_A: rd_nxt = {24'h00_0000, lat_a_r};
        icm_pkg::ADR_LAT_B: rd_nxt = {30'h0000_0000, lat_b_r};
        icm_pkg::ADR_LAT_C: rd_nxt = {30'h0000_0000, lat_c_r};
        icm_pkg::ADR_IEN_A: rd_nxt = {24'h00_0000, ien_a_r};
        icm_pkg::ADR_IEN_B: rd_nxt = {28'h000_0000, ien_b_r};
        icm_pkg::ADR_ALARM: rd_nxt = {24'h00_0000, alarm_w};
        icm_pkg::ADR_STATE: rd_nxt = {29'h0000_0000, aux_locked_r,
                                      main_lol_o, main_mini_holdover_o};
        default: rd_nxt = 32'h0000_0000;
      endcase
    end
  end
endmodule

//--- icm_ref_gen.sv
`timescale 1ns/100ps
// ****
// far-side reference clocks
// ****
module icm_ref_gen #(
  parameter int HALF_NS = 2000
) (
  input wire logic [7:0] run_i,
  output logic [7:0] ref_o
);
  // odd 3 ns offset keeps ref edges off the system clock edge
  // a stopped reference stands still at its last level
  initial begin
    ref_o = 8'h00;
    #3;
    forever begin
      #(HALF_NS);
      ref_o = ref_o ^ run_i;
    end
  end
endmodule

//--- icm_top_monitor.sv
`timescale 1ns/100ps
module icm_top_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [7:0] ref_clk_i,
  input wire logic [2:0] main_sel_i,
  input wire logic wb_ack_o,
  input wire logic [7:0] lock_tick_o,
  input wire logic main_mini_holdover_o,
  input wire logic main_lol_o
);
  // ****
  // helper logic
  // ****
  logic [5:0] hist_r;
  logic prev_r;
  logic [7:0] quiet_r;
  always_ff @(posedge clk_i) begin
    hist_r <= {hist_r[4:0], ref_clk_i[0]};
  end
  // saturating count of cycles the main reference pin stood still
  always_ff @(posedge clk_i) begin
    prev_r <= ref_clk_i[main_sel_i];
    if (rst_i || prev_r != ref_clk_i[main_sel_i]) begin
      quiet_r <= 8'h00;
    end else if (quiet_r != 8'hFF) begin
      quiet_r <= quiet_r + 8'h01;
    end
  end
  // ****
  // assertions
  // ****
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  a_bus_answer: assert property (s_req |=> wb_ack_o)
    else $error("request not answered next cycle");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_lol_in_hold: assert property (main_lol_o |-> main_mini_holdover_o)
    else $error("loss of lock outside holdover");
  a_tick_single: assert property (
    (lock_tick_o & $past(lock_tick_o)) == 8'h00)
    else $error("lock tick wider than one cycle");
  a_tick_after_edge: assert property (lock_tick_o[0] |->
    hist_r != 6'h00 && hist_r != 6'h3F)
    else $error("lock tick without recent ref edge");
  a_hold_quiet: assert property ($rose(main_mini_holdover_o) |->
    quiet_r == 8'hFF)
    else $error("holdover while reference active");
  a_lol_leave: assert property ($fell(main_lol_o) |-> quiet_r < 8'h08)
    else $error("loss of lock left without ref edge");
  a_hold_leave: assert property ($fell(main_mini_holdover_o) |->
    quiet_r < 8'h08)
    else $error("holdover left without ref edge");
endmodule

bind icm_top icm_top_monitor u_icm_top_monitor (.clk_i, .rst_i, .wb_cyc_i,
  .wb_stb_i, .ref_clk_i, .main_sel_i, .wb_ack_o, .lock_tick_o,
  .main_mini_holdover_o, .main_lol_o);

//--- tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o;
  logic [7:0] wb_adr_i, ref_clk_i, aux_usable_i, ref_valid_o, lock_tick_o;
  logic [7:0] run_r;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd_r;
  logic [2:0] main_sel_i, aux_sel_i;
  logic main_mini_holdover_o, main_lol_o, main_input_select_a_err_o, aux_input_select_a_err_o;
  logic aux_locked_o, ref_fail_pin_o;
  int fail_count = 0;
  int n_checks = 0;
  int ticks;
  // tick table: input 0 config, pdiv, ticks per 8 ref edges
  localparam logic [31:0] T_CFG [6] = '{32'h0190_0000, 32'h0190_0041,
    32'h0190_0020, 32'h0190_0001, 32'h0190_0002, 32'h0190_0003};
  localparam logic [31:0] T_PDIV [6] = '{32'h0000_0000, 32'h0000_0001,
    32'h0000_0000, 32'h0000_0001, 32'h0000_0000, 32'h0000_0007};
  localparam logic [31:0] T_EXP [6] = '{32'h0000_0008, 32'h0000_0008,
    32'h0000_0004, 32'h0000_0004, 32'h0000_0002, 32'h0000_0001};

  icm_top #(.INTERVAL_CYCLES(2000)) u_icm_top (.clk_i, .rst_i, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .ref_clk_i, .main_sel_i, .aux_sel_i, .aux_usable_i,
    .ref_valid_o, .lock_tick_o, .main_mini_holdover_o, .main_lol_o,
    .main_input_select_a_err_o, .aux_input_select_a_err_o, .aux_locked_o, .ref_fail_pin_o,
    .irq_o);
  icm_ref_gen u_icm_ref_gen (.run_i(run_r), .ref_o(ref_clk_i));

  // ****
  // tasks
  // ****
  task automatic report_and_stop();
    if (fail_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic we, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd_r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    cmp(rd_r & m, e);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // ****
  // tests
  // ****
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    #900_000;
    fail_count++;
    report_and_stop();
  end
  initial begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h8;
    {wb_adr_i, wb_sel_i, wb_dat_i} = 44'h0;
    run_r = 8'hFF;
    main_sel_i = 3'h2;
    aux_sel_i = 3'h3;
    aux_usable_i = 8'h08;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(icm_pkg::ADR_CTRL, 32'hFFFF_FFFF, icm_pkg::CTRL_RST);
    rd(icm_pkg::ADR_DIVR, 32'hFFFF_FFFF, {16'h0000, icm_pkg::DIVR_RST});
    rd(8'h30, 32'hFFFF_FFFF, icm_pkg::BKT_RST);
    rd(8'h40, 32'hFFFF_FFFF, icm_pkg::CFG_RST);
    rd(8'h44, 32'hFFFF_FFFF, icm_pkg::PDIV_RST);
    wr(8'hFC, 32'hFFFF_FFFF);
    rd(8'hFC, 32'hFFFF_FFFF, 32'h0000_0000);
    // all inputs at 400-cycle nominal period, then clear startup flags
    for (int i = 0; i < 8; i++) wr(8'h40 + 8'(8 * i), 32'h0190_0000);
    idle(2000);
    wr(icm_pkg::ADR_LAT_A, 32'h0000_00FF);
    rd(icm_pkg::ADR_LAT_A, 32'h0000_00FF, 32'h0000_0000);
    rd(icm_pkg::ADR_VALID_A, 32'h0000_00FF, 32'h0000_00FF);
    wr(icm_pkg::ADR_DIVR, 32'h0000_0003);
    for (int i = 0; i < 6; i++) begin
      wr(8'h44, T_PDIV[i]);
      wr(8'h40, T_CFG[i]);
      idle(800);
      ticks = 0;
      repeat (3200) begin
        @(posedge clk_i);
        if (lock_tick_o[0] === 1'b1) ticks++;
      end
      cmp(ticks, T_EXP[i]);
    end
    // input 1 off nominal by a third
    wr(8'h48, 32'h012C_0000);
    aux_usable_i <= 8'h02;
    idle(1600);
    cmp(ref_valid_o, 8'hFD);
    rd(icm_pkg::ADR_LAT_C, 32'h0000_0001, 32'h0000_0001);
    wr(icm_pkg::ADR_IEN_A, 32'h0000_0002);
    idle(2);
    cmp(irq_o, 1'b1);
    wr(icm_pkg::ADR_LAT_A, 32'h0000_00FF);
    idle(2);
    cmp(irq_o, 1'b0);
    wr(icm_pkg::ADR_CTRL, 32'h0000_0000);
    idle(10);
    cmp(ref_valid_o, 8'hFF);
    cmp(irq_o, 1'b1);
    wr(icm_pkg::ADR_IEN_A, 32'h0000_0000);
    idle(2);
    cmp(irq_o, 1'b0);
    aux_usable_i <= 8'h08;
    // main reference stops, loss-of-lock control off then on
    wr(icm_pkg::ADR_LAT_B, 32'h0000_0003);
    wr(icm_pkg::ADR_CTRL, 32'h0000_0002);
    run_r[2] <= 1'b0;
    idle(1600);
    cmp({main_mini_holdover_o, main_lol_o, ref_fail_pin_o}, 3'h5);
    cmp({main_input_select_a_err_o, aux_input_select_a_err_o}, 2'h2);
    rd(icm_pkg::ADR_LAT_B, 32'h0000_0003, 32'h0000_0001);
    run_r[2] <= 1'b1;
    idle(900);
    cmp(main_mini_holdover_o, 1'b0);
    wr(icm_pkg::ADR_LAT_B, 32'h0000_0003);
    wr(icm_pkg::ADR_CTRL, 32'h0000_0006);
    run_r[2] <= 1'b0;
    idle(1600);
    cmp({main_mini_holdover_o, main_lol_o}, 2'h3);
    rd(icm_pkg::ADR_LAT_B, 32'h0000_0003, 32'h0000_0003);
    run_r[2] <= 1'b1;
    idle(900);
    cmp(main_lol_o, 1'b0);
    // aux reference stops
    wr(icm_pkg::ADR_LAT_B, 32'h0000_0003);
    run_r[3] <= 1'b0;
    idle(1600);
    cmp(aux_locked_o, 1'b0);
    cmp({main_input_select_a_err_o, aux_input_select_a_err_o}, 2'h1);
    rd(icm_pkg::ADR_LAT_B, 32'h0000_0001, 32'h0000_0000);
    run_r[3] <= 1'b1;
    // bucket 1: capacity 3 >= declare 2 > clear 1, decay every interval
    wr(8'h34, 32'h0001_0203);
    wr(8'h60, 32'h0190_0004);
    run_r[4] <= 1'b0;
    idle(16000);
    rd(icm_pkg::ADR_ALARM, 32'h0000_0010, 32'h0000_0010);
    cmp(ref_valid_o[4], 1'b0);
    run_r[4] <= 1'b1;
    idle(12000);
    rd(icm_pkg::ADR_ALARM, 32'h0000_0010, 32'h0000_0000);
    cmp(ref_valid_o[4], 1'b1);
    report_and_stop();
  end
endmodule
